// ===== rtc_consts.svh
// Constants of the relay threshold controller: timing, register map, fields, limits
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH
// Timing
`define RTC_CLK_PERIOD_NS 5
`define RTC_TENTH_S_NS 100000000
`define RTC_TENTHS_PER_STEP 60
`define RTC_CYC_W 25
`define RTC_SUB_W 6
// Per-relay block offsets inside each 32-byte slot
`define RTC_OFF_CFG 5'h00
`define RTC_OFF_THR1 5'h04
`define RTC_OFF_THR2 5'h08
`define RTC_OFF_HYSTERESIS_HALF_WIDTH 5'h0C
`define RTC_OFF_TON 5'h10
`define RTC_OFF_TURN_OFF_DELAY 5'h14
// Global registers
`define RTC_OFF_BUZZER_MENU 8'h80
`define RTC_OFF_TMO 8'h84
`define RTC_OFF_STATUS 8'h88
`define RTC_OFF_CMD 8'h8C
// Relay configuration fields
`define RTC_CFG_W 7
`define RTC_CFG_MODE 2:0
`define RTC_CFG_UNIT 3
`define RTC_CFG_REACT 5:4
`define RTC_CFG_PEAK 6
// Buzzer configuration fields
`define RTC_BUZZER_MENU_W 5
`define RTC_BUZZER_MENU_FAULT 0
`define RTC_BUZZER_MENU_RELAY_LSB 1
// Status fields
`define RTC_STAT_LINK 8
`define RTC_STAT_BUZ 9
`define RTC_STAT_MEAS 10
// Value limits
`define RTC_THR_MIN 16'hFC19
`define RTC_THR_MAX 16'h270F
`define RTC_LIM_999 10'h3E7
`endif

// ===== rtc_panel_model.sv
// Panel side model: relay coils, lamps and buzzer seen from outside
`timescale 1ns/100ps
module rtc_panel_model (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic [3:0] i_coil,
   input wire logic [3:0] i_lamp,
   input wire logic i_buzzer,
   output logic o_bad,
   output logic [7:0] o_beeps
);
   logic buz_q;
   // Lamp must track its coil in every setting; sticky until reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         o_bad <= 1'b0;
      end else if (i_lamp !== i_coil) begin
         o_bad <= 1'b1;
      end
   end
   // Count buzzer onsets like a listener would
   always_ff @(posedge i_mclk) begin
      buz_q <= i_buzzer;
      if (!i_rst_n) begin
         o_beeps <= 8'h00;
      end else if (i_buzzer && !buz_q) begin
         o_beeps <= o_beeps + 8'h01;
      end
   end
endmodule

// ===== rtc_pkg.sv
// Types shared by the relay threshold controller modules
`include "rtc_consts.svh"
package rtc_pkg;
   typedef enum logic [2:0] {
      inactive_setting = 3'h0,
      mode_direct = 3'h1,
      mode_inverted = 3'h2,
      mode_inside = 3'h3,
      mode_outside = 3'h4,
      mode_bus = 3'h5
   } rtc_mode_e;
   typedef enum logic [1:0] {
      hold_state_setting = 2'h0,
      react_force_on = 2'h1,
      react_force_off = 2'h2
   } rtc_react_e;
   typedef logic [`RTC_CYC_W-1:0] rtc_cyc_t;
   typedef logic [`RTC_SUB_W-1:0] rtc_sub_t;
   typedef struct packed {
      rtc_cyc_t cyc;
      rtc_sub_t sub;
      logic tick_sec;
      logic tick_min;
   } rtc_tick_s;
   typedef struct packed {
      logic relay;
      logic lamp;
      logic [9:0] cnt;
   } rtc_chan_s;
endpackage

// ===== rtc_relay_chan.sv
// One relay channel: delay timing, fault override and output flops
`timescale 1ns/100ps
module rtc_relay_chan (
   input logic i_mclk,
   input logic i_rst_n,
   input logic i_tick,
   input logic i_want_on,
   input logic i_want_off,
   input logic [9:0] i_ton,
   input logic [9:0] i_turn_off_delay,
   input rtc_pkg::rtc_mode_e i_mode,
   input logic i_fault,
   input rtc_pkg::rtc_react_e i_react,
   input logic i_bus_cmd,
   output logic o_relay,
   output logic o_lamp
);
   rtc_pkg::rtc_chan_s st, next_st;
   logic pending;
   logic [9:0] limit;

   // Only the move away from the present state is timed
   assign pending = st.relay ? i_want_off : i_want_on;
   assign limit = st.relay ? i_turn_off_delay : i_ton;

   // Fault first, then setting, then the delayed threshold decision
   always_comb begin
      next_st = st;
      if (i_fault && i_react == rtc_pkg::react_force_on) begin
         next_st.relay = 1'b1;
         next_st.cnt = '0;
      end else if (i_fault && i_react == rtc_pkg::react_force_off) begin
         next_st.relay = 1'b0;
         next_st.cnt = '0;
      end else if (i_fault) begin
         next_st.cnt = '0; // Frozen state
      end else if (i_mode == rtc_pkg::inactive_setting) begin
         next_st.relay = 1'b0;
         next_st.cnt = '0;
      end else if (i_mode == rtc_pkg::mode_bus) begin
         next_st.relay = i_bus_cmd;
         next_st.cnt = '0;
      end else if (!pending) begin
         next_st.cnt = '0; // Interrupted wait starts over
      end else if (st.cnt >= limit) begin
         next_st.relay = !st.relay;
         next_st.cnt = '0;
      end else if (i_tick) begin
         next_st.cnt = st.cnt + 10'h001;
      end
      next_st.lamp = next_st.relay;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_relay = st.relay;
   assign o_lamp = st.lamp;
endmodule

// ===== rtc_relay_threshold_ctrl.sv
// Relay, lamp and buzzer controller with APB register file
`timescale 1ns/100ps
`include "rtc_consts.svh"

// Functional notes
// - First threshold per relay, signed -999..9999, centre of the hysteresis band.
// - Second threshold is settable only in inside-band or outside-band setting.
// - Hysteresis 0..999; band is twice it; no change inside the band.
// - Inactive setting keeps the relay off unless the fault reaction forces it on.
// - Direct: on above threshold plus hysteresis, off below threshold minus it.
// - Inverted: off above threshold plus hysteresis, on below threshold minus it.
// - Inside band: on between lower-plus and upper-minus hysteresis, off outside.
// - Outside band: on above upper-plus or below lower-minus, off inside.
// - Upper and lower thresholds are the larger and smaller, in any order.
// - Bus-driven setting follows link commands only, ignoring the measurement.
// - Each lamp lights whenever its relay is closed, in every setting.
// - Link-commanded relay state is not kept across power loss.
// - Relay turns on after the on condition lasts the turn-on delay, 0..99.9.
// - Relay turns off after the off condition lasts the turn-off delay, 0..99.9.
// - A border crossing shorter than the delay leaves the relay unchanged.
// - Each relay counts its delays in seconds or minutes, per selector.
// - On fault the relay holds, is forced on, or forced off, per relay.
// - Threshold settings treat an out-of-range measurement as a fault.
// - Bus setting treats link silence beyond the timeout as a fault.
// - Force-on reaction energises the relay in a fault even when inactive.
// - Decisions use the present value or the peak while peak detection runs.
// - With its fault enable set, the buzzer sounds on any fault.
// - Relays one to four sound the buzzer on activation when enabled.
// - Any front-panel button silences the buzzer.
module rtc_relay_threshold_ctrl #(
   parameter int unsigned NUM_RELAYS = 4,
   parameter int unsigned TENTH_CYCLES = `RTC_TENTH_S_NS / `RTC_CLK_PERIOD_NS
) (
   input logic i_mclk,
   input logic i_rst_n,
   input logic i_psel,
   input logic i_penable,
   input logic i_pwrite,
   input logic [7:0] i_paddr,
   input logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input logic signed [15:0] i_meas_value,
   input logic signed [15:0] i_peak_value,
   input logic i_peak_active,
   input logic i_meas_fault,
   input logic i_link_rx,
   input logic i_link_cmd_valid,
   input logic [NUM_RELAYS-1:0] i_link_cmd,
   input logic i_button,
   output logic [NUM_RELAYS-1:0] o_relay,
   output logic [NUM_RELAYS-1:0] o_lamp,
   output logic o_buzzer
);
   // Address decode gives two index bits, so at most four relays
   localparam int N = NUM_RELAYS;

   typedef struct packed {
      logic [N-1:0][`RTC_CFG_W-1:0] cfg;
      logic [N-1:0][15:0] thr1;
      logic [N-1:0][15:0] thr2;
      logic [N-1:0][9:0] hysteresis_half_width;
      logic [N-1:0][9:0] ton;
      logic [N-1:0][9:0] turn_off_delay;
      logic [`RTC_BUZZER_MENU_W-1:0] buzzer_menu;
      logic [15:0] tmo;
      logic [15:0] silence;
      logic link_fault;
      logic [N-1:0] cmd;
      logic [N-1:0] relay_prev;
      logic fault_prev;
      logic buzzer;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } rtc_main_s;

   rtc_main_s st, next_st;
   logic tick_sec;
   logic tick_min;
   logic [N-1:0] relay;
   logic [N-1:0] lamp;
   logic [N-1:0] want_on;
   logic [N-1:0] want_off;
   logic [N-1:0] fault;
   logic [N-1:0] buzzer_menu_en;
   logic any_fault;
   logic access;
   logic wr_en;
   logic mapped;
   logic thr2_open;
   logic buz_set;
   logic [1:0] ridx;
   logic [4:0] roff;
   logic [31:0] rdata;
   rtc_pkg::rtc_mode_e sel_mode;

   // Out-of-range writes saturate rather than wrap
   function automatic logic [15:0] clamp_thr(input logic [31:0] w);
      logic signed [31:0] s;
      s = $signed(w);
      if (s < 32'($signed(`RTC_THR_MIN))) begin
         clamp_thr = `RTC_THR_MIN;
      end else if (s > 32'($signed(`RTC_THR_MAX))) begin
         clamp_thr = `RTC_THR_MAX;
      end else begin
         clamp_thr = w[15:0];
      end
   endfunction

   function automatic logic [9:0] clamp_lim(input logic [31:0] w);
      if (w > 32'(`RTC_LIM_999)) begin
         clamp_lim = `RTC_LIM_999;
      end else begin
         clamp_lim = w[9:0];
      end
   endfunction

   rtc_tick_gen #(
      .TENTH_CYCLES(TENTH_CYCLES)
   ) u_tick (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .o_tick_sec(tick_sec),
      .o_tick_min(tick_min)
   );

   assign any_fault = i_meas_fault | st.link_fault;
   assign buzzer_menu_en = st.buzzer_menu[`RTC_BUZZER_MENU_RELAY_LSB +: N];

   // Per relay: input choice, band decision and the timed channel
   for (genvar g = 0; g < N; g++) begin : g_relay
      logic signed [17:0] v;
      logic signed [17:0] t;
      logic signed [17:0] t2;
      logic signed [17:0] lo;
      logic signed [17:0] hi;
      logic signed [17:0] h;
      logic on;
      logic off;
      rtc_pkg::rtc_mode_e mode;
      rtc_pkg::rtc_react_e react;

      assign mode = rtc_pkg::rtc_mode_e'(st.cfg[g][`RTC_CFG_MODE]);
      assign react = rtc_pkg::rtc_react_e'(st.cfg[g][`RTC_CFG_REACT]);
      // Peak is trusted only while the detector runs
      assign v = (st.cfg[g][`RTC_CFG_PEAK] && i_peak_active) ?
                 18'(i_peak_value) : 18'(i_meas_value);
      // Two bits of headroom so edge +/- hysteresis never wraps
      assign t = 18'($signed(st.thr1[g]));
      assign t2 = 18'($signed(st.thr2[g]));
      assign h = $signed(18'(st.hysteresis_half_width[g]));
      assign lo = (t < t2) ? t : t2;
      assign hi = (t < t2) ? t2 : t;

      // Both edges checked every cycle; between them nothing is wanted
      always_comb begin
         on = 1'b0;
         off = 1'b0;
         case (mode)
            rtc_pkg::mode_direct: begin
               on = v > t + h;
               off = v < t - h;
            end
            rtc_pkg::mode_inverted: begin
               on = v < t - h;
               off = v > t + h;
            end
            rtc_pkg::mode_inside: begin
               on = (v > lo + h) && (v < hi - h);
               off = (v < lo - h) || (v > hi + h);
            end
            rtc_pkg::mode_outside: begin
               on = (v > hi + h) || (v < lo - h);
               off = (v > lo + h) && (v < hi - h);
            end
            default: begin
               on = 1'b0;
               off = 1'b0;
            end
         endcase
      end

      assign want_on[g] = on;
      assign want_off[g] = off;
      // Fault source depends on what drives the relay
      assign fault[g] = (mode == rtc_pkg::mode_bus) ?
                        st.link_fault : i_meas_fault;

      rtc_relay_chan u_chan (
         .i_mclk(i_mclk),
         .i_rst_n(i_rst_n),
         .i_tick(st.cfg[g][`RTC_CFG_UNIT] ? tick_min : tick_sec),
         .i_want_on(on),
         .i_want_off(off),
         .i_ton(st.ton[g]),
         .i_turn_off_delay(st.turn_off_delay[g]),
         .i_mode(mode),
         .i_fault(fault[g]),
         .i_react(react),
         .i_bus_cmd(st.cmd[g]),
         .o_relay(relay[g]),
         .o_lamp(lamp[g])
      );
   end

   // APB decode; writes land on the edge that samples pready high
   assign access = i_psel & i_penable;
   assign wr_en = access & i_pwrite & st.pready;
   assign ridx = i_paddr[6:5];
   assign roff = i_paddr[4:0];
   assign sel_mode = rtc_pkg::rtc_mode_e'(st.cfg[ridx][`RTC_CFG_MODE]);
   assign thr2_open = (sel_mode == rtc_pkg::mode_inside) ||
                      (sel_mode == rtc_pkg::mode_outside);

   // Read mux and map check; misaligned or empty slots answer with an error
   always_comb begin
      rdata = '0;
      mapped = (i_paddr[1:0] == 2'h0);
      if (!i_paddr[7]) begin
         if (32'(ridx) >= N) begin
            mapped = 1'b0;
         end else begin
            case (roff)
               `RTC_OFF_CFG: rdata = 32'(st.cfg[ridx]);
               `RTC_OFF_THR1: rdata = {{16{st.thr1[ridx][15]}}, st.thr1[ridx]};
               `RTC_OFF_THR2: begin
                  if (thr2_open) begin
                     rdata = {{16{st.thr2[ridx][15]}}, st.thr2[ridx]};
                  end
               end
               `RTC_OFF_HYSTERESIS_HALF_WIDTH: rdata = 32'(st.hysteresis_half_width[ridx]);
               `RTC_OFF_TON: rdata = 32'(st.ton[ridx]);
               `RTC_OFF_TURN_OFF_DELAY: rdata = 32'(st.turn_off_delay[ridx]);
               default: mapped = 1'b0;
            endcase
         end
      end else begin
         case (i_paddr)
            `RTC_OFF_BUZZER_MENU: rdata = 32'(st.buzzer_menu);
            `RTC_OFF_TMO: rdata = 32'(st.tmo);
            `RTC_OFF_STATUS: begin
               rdata[N-1:0] = relay;
               rdata[`RTC_STAT_LINK] = st.link_fault;
               rdata[`RTC_STAT_BUZ] = st.buzzer;
               rdata[`RTC_STAT_MEAS] = i_meas_fault;
            end
            `RTC_OFF_CMD: rdata = 32'(st.cmd);
            default: mapped = 1'b0;
         endcase
      end
   end

   // Buzzer triggers: fault onset and fresh relay activations
   assign buz_set = (st.buzzer_menu[`RTC_BUZZER_MENU_FAULT] & any_fault & ~st.fault_prev) |
                    (|(relay & ~st.relay_prev & buzzer_menu_en));

   always_comb begin
      next_st = st;
      // One wait state: pready rises for one cycle per access
      next_st.pready = access & ~st.pready;
      next_st.pslverr = access & ~st.pready & ~mapped;
      if (access && !st.pready) begin
         next_st.prdata = i_pwrite ? '0 : rdata;
      end
      if (wr_en && mapped && !i_paddr[7]) begin
         case (roff)
            `RTC_OFF_CFG: next_st.cfg[ridx] = i_pwdata[`RTC_CFG_W-1:0];
            `RTC_OFF_THR1: next_st.thr1[ridx] = clamp_thr(i_pwdata);
            `RTC_OFF_THR2: begin
               if (thr2_open) begin
                  next_st.thr2[ridx] = clamp_thr(i_pwdata);
               end
            end
            `RTC_OFF_HYSTERESIS_HALF_WIDTH: next_st.hysteresis_half_width[ridx] = clamp_lim(i_pwdata);
            `RTC_OFF_TON: next_st.ton[ridx] = clamp_lim(i_pwdata);
            `RTC_OFF_TURN_OFF_DELAY: next_st.turn_off_delay[ridx] = clamp_lim(i_pwdata);
            default: next_st.cfg = st.cfg;
         endcase
      end else if (wr_en && mapped) begin
         case (i_paddr)
            `RTC_OFF_BUZZER_MENU: next_st.buzzer_menu = i_pwdata[`RTC_BUZZER_MENU_W-1:0];
            `RTC_OFF_TMO: next_st.tmo = i_pwdata[15:0];
            default: next_st.buzzer_menu = st.buzzer_menu;
         endcase
      end
      // Commanded states live only in flops and clear at reset
      if (i_link_cmd_valid) begin
         next_st.cmd = i_link_cmd;
      end
      // Silence counted in tenths of a second, saturating
      if (i_link_rx || i_link_cmd_valid) begin
         next_st.silence = '0;
      end else if (tick_sec && st.silence != 16'hFFFF) begin
         next_st.silence = st.silence + 16'h0001;
      end
      next_st.link_fault = (st.tmo != 16'h0000) && (st.silence > st.tmo);
      next_st.relay_prev = relay;
      next_st.fault_prev = any_fault;
      // A new trigger beats a button press in the same cycle
      if (buz_set) begin
         next_st.buzzer = 1'b1;
      end else if (i_button) begin
         next_st.buzzer = 1'b0;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Relay and lamp bits come from the channel flops
   assign o_prdata = st.prdata;
   assign o_pready = st.pready;
   assign o_pslverr = st.pslverr;
   assign o_relay = relay;
   assign o_lamp = lamp;
   assign o_buzzer = st.buzzer;

   default clocking cb_main @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);

   a_apb_wait: assert property (access && !o_pready |=> o_pready ##1 !o_pready)
      else $error("APB access not answered after one wait state");
   a_thr_range: assert property (
      wr_en && mapped && !i_paddr[7] && roff == `RTC_OFF_THR1 |=>
      $signed(st.thr1[0]) >= $signed(`RTC_THR_MIN) &&
      $signed(st.thr1[0]) <= $signed(`RTC_THR_MAX))
      else $error("First threshold outside its range");
   a_thr2_locked: assert property (
      wr_en && !i_paddr[7] && roff == `RTC_OFF_THR2 && !thr2_open |=> $stable(st.thr2))
      else $error("Second threshold written outside band settings");
   a_hysteresis_half_width_range: assert property (st.hysteresis_half_width[0] <= `RTC_LIM_999)
      else $error("Hysteresis above its limit");
   a_inactive_off: assert property (
      st.cfg[0][`RTC_CFG_MODE] == rtc_pkg::inactive_setting && !fault[0] |=> !o_relay[0])
      else $error("Inactive relay energised without fault");
   a_force_on: assert property (
      fault[0] && st.cfg[0][`RTC_CFG_REACT] == rtc_pkg::react_force_on |=> o_relay[0])
      else $error("Force-on reaction did not energise relay");
   a_short_cross: assert property (
      !o_relay[0] && !want_on[0] && !fault[0] && g_relay[0].mode != rtc_pkg::mode_bus
      |=> !o_relay[0])
      else $error("Relay closed without a persisting on condition");
   a_lamp_relay: assert property (o_lamp == o_relay)
      else $error("Lamp differs from relay state");
   a_link_fault: assert property (
      st.tmo != 16'h0000 && st.silence > st.tmo |=> st.link_fault)
      else $error("Link silence fault not raised");
   a_link_clear: assert property (i_link_rx |=> ##1 !st.link_fault)
      else $error("Link fault stayed after received data");
   a_buzz_relay: assert property (
      relay[0] && !st.relay_prev[0] && buzzer_menu_en[0] |=> o_buzzer)
      else $error("Relay activation did not sound buzzer");
   a_buzz_silence: assert property (i_button && !buz_set |=> !o_buzzer)
      else $error("Button press did not silence buzzer");
endmodule

// ===== rtc_relay_threshold_ctrl_tb.sv
// Self-checking bench of the relay threshold controller
`timescale 1ns/100ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s exp %0h got %0h", nm, e, g); end end
module rtc_relay_threshold_ctrl_tb;
   logic i_mclk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, pact = 0, mflt = 0;
   logic lrx = 0, lcv = 0, btn = 0, o_pready, o_pslverr, o_buzzer, bad;
   logic [7:0] paddr = 8'h00, beeps;
   logic [31:0] pwdata = 32'h0000_0000, o_prdata, rd;
   logic signed [15:0] meas = 16'h0000, peak = 16'h0000;
   logic [3:0] lcmd = 4'h0, o_relay, o_lamp;
   logic er, p;
   int n_fail = 0, num_checks = 0, seed = 69, t1, t2, h, v;
   rtc_relay_threshold_ctrl #(.TENTH_CYCLES(10)) uut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_meas_value(meas),
      .i_peak_value(peak), .i_peak_active(pact), .i_meas_fault(mflt), .i_link_rx(lrx),
      .i_link_cmd_valid(lcv), .i_link_cmd(lcmd), .i_button(btn), .o_relay(o_relay),
      .o_lamp(o_lamp), .o_buzzer(o_buzzer));
   rtc_panel_model far (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_coil(o_relay),
      .i_lamp(o_lamp), .i_buzzer(o_buzzer), .o_bad(bad), .o_beeps(beeps));
   initial forever #2.5 i_mclk = ~i_mclk;
   task automatic end_of_test;
      if (n_fail == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_mclk);
   endtask
   // One APB transfer; waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge i_mclk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_mclk);
      pen <= 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge i_mclk);
         if (o_pready === 1'b1) break;
      end
      rd = o_prdata;
      er = o_pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (k == 20) begin n_fail++; end_of_test(); end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic ee);
      apb(1'b0, a, 32'h0000_0000);
      `CHK("prdata", e, rd)
      `CHK("pslverr", ee, er)
   endtask
   task automatic drv(input int x);
      @(posedge i_mclk);
      meas <= 16'(x);
   endtask
   // Expected relay state with hysteresis and hold zone
   function automatic logic exp_rel(input int m, x, a, b, hh, input logic pv);
      int lo, hi;
      lo = a < b ? a : b;
      hi = a < b ? b : a;
      case (m)
         1: return x > a + hh ? 1'b1 : (x < a - hh ? 1'b0 : pv);
         2: return x > a + hh ? 1'b0 : (x < a - hh ? 1'b1 : pv);
         3: return (x > lo + hh && x < hi - hh) ? 1'b1 : ((x < lo - hh || x > hi + hh) ? 1'b0 : pv);
         4: return (x > lo + hh && x < hi - hh) ? 1'b0 : ((x < lo - hh || x > hi + hh) ? 1'b1 : pv);
         default: return 1'b0;
      endcase
   endfunction
   initial begin
      cyc(6);
      i_rst_n <= 1'b1;
      cyc(2);
      // Reset state and refused addresses
      rdc(8'h00, 32'h0000_0000, 1'b0);
      `CHK("relay", 4'h0, o_relay)
      rdc(8'h90, 32'h0000_0000, 1'b1);
      rdc(8'h02, 32'h0000_0000, 1'b1);
      // Saturation of thresholds and hysteresis
      apb(1'b1, 8'h04, 32'hFFFF_F830);
      rdc(8'h04, 32'hFFFF_FC19, 1'b0);
      apb(1'b1, 8'h04, 32'h0000_4E20);
      rdc(8'h04, 32'h0000_270F, 1'b0);
      apb(1'b1, 8'h0C, 32'h0000_1388);
      rdc(8'h0C, 32'h0000_03E7, 1'b0);
      // Second threshold gated by setting
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h08, 32'h0000_0055);
      rdc(8'h08, 32'h0000_0000, 1'b0);
      apb(1'b1, 8'h00, 32'h0000_0003);
      apb(1'b1, 8'h08, 32'h0000_0055);
      rdc(8'h08, 32'h0000_0055, 1'b0);
      // Random sweeps across the threshold settings, thresholds swapped in band modes
      for (int m = 0; m < 5; m++) begin
         t1 = $random(seed) % 500;
         t2 = t1 + 100 + {$random(seed)} % 200;
         h = {$random(seed)} % 40;
         apb(1'b1, 8'h00, 32'(m));
         apb(1'b1, 8'h04, 32'(t2));
         apb(1'b1, 8'h08, 32'(t1));
         apb(1'b1, 8'h0C, 32'(h));
         p = 1'b0;
         for (int i = 0; i < 12; i++) begin
            v = (i == 0) ? t1 - 200 : t1 - 150 + {$random(seed)} % 500;
            drv(v);
            cyc(4);
            p = exp_rel(m, v, (m < 3) ? t2 : t1, t2, h, p);
            `CHK("relay", p, o_relay[0])
            `CHK("lamp", p, o_lamp[0])
         end
      end
      // Peak value used only while peak detection runs
      apb(1'b1, 8'h00, 32'h0000_0041);
      apb(1'b1, 8'h04, 32'h0000_0064);
      apb(1'b1, 8'h0C, 32'h0000_0000);
      drv(0);
      peak <= 16'h01F4;
      cyc(4);
      `CHK("relay", 1'b0, o_relay[0])
      pact <= 1'b1;
      cyc(4);
      `CHK("relay", 1'b1, o_relay[0])
      pact <= 1'b0;
      cyc(4);
      `CHK("relay", 1'b0, o_relay[0])
      // Delays: short crossings ignored, timer restarts
      apb(1'b1, 8'h00, 32'h0000_0001);
      apb(1'b1, 8'h10, 32'h0000_0003);
      apb(1'b1, 8'h14, 32'h0000_0002);
      drv(200);
      cyc(15);
      drv(0);
      cyc(4);
      `CHK("relay", 1'b0, o_relay[0])
      drv(200);
      cyc(60);
      `CHK("relay", 1'b1, o_relay[0])
      drv(0);
      cyc(8);
      drv(200);
      cyc(4);
      `CHK("relay", 1'b1, o_relay[0])
      drv(0);
      cyc(50);
      `CHK("relay", 1'b0, o_relay[0])
      // Tick phase is free: the first minute tick may come at once, the second a step later
      apb(1'b1, 8'h00, 32'h0000_0009);
      apb(1'b1, 8'h10, 32'h0000_0002);
      drv(200);
      cyc(590);
      `CHK("relay", 1'b0, o_relay[0])
      cyc(650);
      `CHK("relay", 1'b1, o_relay[0])
      // Fault forces an inactive relay on and sounds the buzzer
      apb(1'b1, 8'h00, 32'h0000_0010);
      apb(1'b1, 8'h80, 32'h0000_0001);
      mflt <= 1'b1;
      cyc(4);
      `CHK("relay", 1'b1, o_relay[0])
      `CHK("buzzer", 1'b1, o_buzzer)
      btn <= 1'b1;
      cyc(1);
      btn <= 1'b0;
      cyc(3);
      `CHK("buzzer", 1'b0, o_buzzer)
      mflt <= 1'b0;
      cyc(4);
      `CHK("relay", 1'b0, o_relay[0])
      // Bus-driven relay, relay buzzer, link silence fault
      apb(1'b1, 8'h80, 32'h0000_0002);
      apb(1'b1, 8'h00, 32'h0000_0025);
      drv(-500);
      lcmd <= 4'h1;
      lcv <= 1'b1;
      cyc(1);
      lcv <= 1'b0;
      cyc(4);
      `CHK("relay", 1'b1, o_relay[0])
      `CHK("buzzer", 1'b1, o_buzzer)
      rdc(8'h8C, 32'h0000_0001, 1'b0);
      cyc(60);
      `CHK("relay", 1'b1, o_relay[0])
      apb(1'b1, 8'h84, 32'h0000_0002);
      cyc(80);
      `CHK("relay", 1'b0, o_relay[0])
      apb(1'b0, 8'h88, 32'h0000_0000);
      `CHK("link fault", 1'b1, rd[8])
      // Received data ends the silence fault and hands the relay back to the link
      lrx <= 1'b1;
      cyc(1);
      lrx <= 1'b0;
      cyc(4);
      `CHK("relay", 1'b1, o_relay[0])
      apb(1'b0, 8'h88, 32'h0000_0000);
      `CHK("link fault", 1'b0, rd[8])
      `CHK("beeps", 8'h02, beeps)
      `CHK("lamp model", 1'b0, bad)
      end_of_test();
   end
endmodule

// ===== rtc_tick_gen.sv
// Tenth-of-second and tenth-of-minute tick divider
`timescale 1ns/100ps
`include "rtc_consts.svh"
module rtc_tick_gen #(
   parameter int unsigned TENTH_CYCLES = `RTC_TENTH_S_NS / `RTC_CLK_PERIOD_NS
) (
   input logic i_mclk,
   input logic i_rst_n,
   output logic o_tick_sec,
   output logic o_tick_min
);
   localparam rtc_pkg::rtc_cyc_t CYC_LAST = rtc_pkg::rtc_cyc_t'(TENTH_CYCLES - 1);
   localparam rtc_pkg::rtc_sub_t SUB_LAST = rtc_pkg::rtc_sub_t'(`RTC_TENTHS_PER_STEP - 1);
   rtc_pkg::rtc_tick_s st, next_st;

   // Minute ticks are cut from second ticks, so both stay in phase
   always_comb begin
      next_st = st;
      next_st.tick_sec = 1'b0;
      next_st.tick_min = 1'b0;
      if (st.cyc == CYC_LAST) begin
         next_st.cyc = '0;
         next_st.tick_sec = 1'b1;
         if (st.sub == SUB_LAST) begin
            next_st.sub = '0;
            next_st.tick_min = 1'b1;
         end else begin
            next_st.sub = st.sub + 1'b1;
         end
      end else begin
         next_st.cyc = st.cyc + 1'b1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign o_tick_sec = st.tick_sec;
   assign o_tick_min = st.tick_min;
endmodule
